// ---- shared/axis_homing_pkg.sv ----
/*
  Shared constants for one motion axis: parameter numbers of the register
  map, field positions, reset values and homing encodings.
  Assumes a host that reaches the parameters by number, one word per access.
*/
package axis_homing_pkg;

  // Parameter numbers; the register port addresses them directly.
  localparam logic [7:0] ADDR_SLOW_RUN_CURRENT   = 8'hB7;
  localparam logic [7:0] ADDR_RANDOM_OFF_MODE    = 8'hB8;
  localparam logic [7:0] ADDR_HOMING_MODE        = 8'hC1;
  localparam logic [7:0] ADDR_HOMING_COARSE      = 8'hC2;
  localparam logic [7:0] ADDR_HOMING_FINE        = 8'hC3;
  localparam logic [7:0] ADDR_END_SWITCH_SPAN    = 8'hC4;
  localparam logic [7:0] ADDR_PRE_ZERO_POSITION  = 8'hC5;
  localparam logic [7:0] ADDR_BOOST_CURRENT      = 8'hC8;
  localparam logic [7:0] ADDR_EXT_INDEX_CONTROL  = 8'hC9;
  localparam logic [7:0] ADDR_FREEWHEEL_DELAY    = 8'hCC;
  localparam logic [7:0] ADDR_LOAD_READOUT       = 8'hCE;
  localparam logic [7:0] ADDR_MOTION_ERROR_FLAGS = 8'hCF;

  // Homing mode field layout.
  localparam int HOME_INVERT_BIT = 7;
  localparam int RIGHT_REF_BIT   = 6;
  localparam logic [5:0] BASE_MODE_MIN = 6'h01;
  localparam logic [5:0] BASE_MODE_MAX = 6'h08;

  // Index control field layout.
  localparam int INDEX_CLEAR_BIT    = 2;
  localparam int INDEX_EVERY_BIT    = 3;
  localparam int INDEX_POLARITY_BIT = 4;

  // Error flag layout.
  localparam int ERR_STALL_BIT     = 0;
  localparam int ERR_DEVIATION_BIT = 1;

  // Reset values.
  localparam logic [7:0]  RST_SLOW_RUN_CURRENT = 8'h00;
  localparam logic [7:0]  RST_HOMING_MODE      = 8'h01;
  localparam logic [10:0] RST_HOMING_SPEED     = 11'h000;
  localparam logic [7:0]  RST_BOOST_CURRENT    = 8'h00;
  localparam logic [4:0]  RST_INDEX_CONTROL    = 5'h00;
  localparam logic [15:0] RST_FREEWHEEL_DELAY  = 16'h0000;

  // Freewheel delay unit: one tick of the delay setting.
  localparam int FREEWHEEL_UNIT_NS = 10_000_000;
  localparam int CLK_PERIOD_NS     = 40;
  localparam int FREEWHEEL_TICK_CYCLES = FREEWHEEL_UNIT_NS / CLK_PERIOD_NS;

  // Homing state codes.
  typedef enum logic [2:0] {
    HS_IDLE  = 3'b000,
    HS_FIRST = 3'b001,
    HS_BACK  = 3'b010,
    HS_FAR   = 3'b011,
    HS_LEAVE = 3'b100,
    HS_DONE  = 3'b101
  } home_state_t;

endpackage : axis_homing_pkg

// ---- rtl/axis_homing_status.sv ----
/*
  One motion axis: current selection, chopper off-time mode, reference
  search, index clearing of the external encoder, freewheel cutoff and
  error flags, with the parameter registers on a simple word port.
  Assumes synchronous switch, index and status inputs; the ramp generator,
  driver and encoder counters live outside and follow the commands given.
*/
`timescale 1ns/100ps
module axis_homing_status
  import axis_homing_pkg::*;
#(
  parameter int TICK_CYCLES = FREEWHEEL_TICK_CYCLES
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Parameter register port.
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  output logic      [31:0] regRdata,
  output logic             regAck,
  // Commands.
  input  wire logic        homingCommand,
  input  wire logic        motionCommand,
  output logic             homingRejected,
  output logic             homingBusy,
  // Motion status from the ramp generator.
  input  wire logic [10:0] actualSpeed,
  input  wire logic        accelerating,
  input  wire logic        motionDone,
  input  wire logic [10:0] thresholdSpeed,
  input  wire logic [10:0] stallStopSpeed,
  input  wire logic [31:0] actualPosition,
  input  wire logic [31:0] encoderPosition,
  input  wire logic [31:0] maxDeviation,
  input  wire logic [9:0]  loadValue,
  input  wire logic [7:0]  maxCurrent,
  // Switches and encoder index.
  input  wire logic        leftStop,
  input  wire logic        rightStop,
  input  wire logic        homeSwitch,
  input  wire logic        indexPulse,
  // Drive outputs.
  output logic [7:0]       motorCurrent,
  output logic             randomOffTime,
  output logic             powerCut,
  output logic             motorStop,
  output logic [10:0]      homingSpeed,
  output logic             homingDirPos,
  output logic             homingMove,
  output logic             zeroPosition,
  output logic             clearExtEncoder
);

  // Refuse a tick count that could never reach its terminal value.
  if (TICK_CYCLES < 1) begin : g_tickCheck
    $error("TICK_CYCLES must be at least one.");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State.
  typedef struct packed {
    logic [7:0]  slowRun;
    logic        randomOff;
    logic [7:0]  homeMode;
    logic [10:0] coarse;
    logic [10:0] fine;
    logic [31:0] span;
    logic [31:0] preZero;
    logic [7:0]  boost;
    logic [4:0]  indexCtl;
    logic [15:0] freeDelay;
    logic [1:0]  errFlags;
    logic [31:0] rdata;
    logic        ack;
    home_state_t hstate;
    logic        secondPass;
    logic [31:0] firstPos;
    logic        indexArmed;
    logic        indexPrev;
    logic        clrEnc;
    logic        zeroPos;
    logic        reject;
    logic [31:0] tickCnt;
    logic [15:0] freeCnt;
    logic        cut;
    logic        stop;
    logic [7:0]  current;
  } state_t;

  state_t stateReg;
  state_t stateNext;

  ////////////////////////////////////////////////////////////////////////////
  // Homing, index and fault decode helpers.
  logic [5:0]  baseMode;
  logic        homeActive;
  logic        refSwitch;
  logic        indexLevel;
  logic        indexEdge;
  logic [31:0] deviation;
  logic        stallStop;
  logic        devStop;

  // Mode decode, switch selection and fault detection.
  always_comb begin
    baseMode   = stateReg.homeMode[5:0] & 6'h3F;
    homeActive = homeSwitch ^ stateReg.homeMode[HOME_INVERT_BIT];
    refSwitch  = stateReg.homeMode[RIGHT_REF_BIT] ? rightStop
                                                  : leftStop;
    indexLevel = stateReg.indexCtl[INDEX_POLARITY_BIT] ? indexPulse
                                                       : !indexPulse;
    indexEdge  = indexLevel && !stateReg.indexPrev;
    deviation  = ($signed(actualPosition) > $signed(encoderPosition))
                 ? actualPosition - encoderPosition
                 : encoderPosition - actualPosition;
    stallStop  = (actualSpeed > stallStopSpeed)
                 && (loadValue == 10'h000);
    devStop    = (maxDeviation != 32'h0000_0000)
                 && (deviation > maxDeviation);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  always_comb begin
    stateNext         = stateReg;
    stateNext.ack     = 1'b0;
    stateNext.zeroPos = 1'b0;
    stateNext.clrEnc  = 1'b0;
    stateNext.reject  = 1'b0;
    stateNext.indexPrev = indexLevel;

    // Register writes.
    if (regWrite) begin
      stateNext.ack = 1'b1;
      unique case (regAddr)
        ADDR_SLOW_RUN_CURRENT:  stateNext.slowRun  = regWdata[7:0];
        ADDR_RANDOM_OFF_MODE:   stateNext.randomOff = regWdata[0];
        ADDR_HOMING_MODE:       stateNext.homeMode = regWdata[7:0];
        ADDR_HOMING_COARSE:     stateNext.coarse   = regWdata[10:0];
        ADDR_HOMING_FINE:       stateNext.fine     = regWdata[10:0];
        ADDR_BOOST_CURRENT:     stateNext.boost    = regWdata[7:0];
        ADDR_EXT_INDEX_CONTROL: begin
          stateNext.indexCtl   = regWdata[4:0];
          stateNext.indexArmed = regWdata[INDEX_CLEAR_BIT];
        end
        ADDR_FREEWHEEL_DELAY:   stateNext.freeDelay = regWdata[15:0];
        default:                stateNext.ack      = 1'b1;
      endcase
    end

    // Register reads; unmapped numbers return zero.
    if (regRead) begin
      stateNext.ack = 1'b1;
      unique case (regAddr)
        ADDR_SLOW_RUN_CURRENT:  stateNext.rdata = {24'h0, stateReg.slowRun};
        ADDR_RANDOM_OFF_MODE:   stateNext.rdata = {31'h0, stateReg.randomOff};
        ADDR_HOMING_MODE:       stateNext.rdata = {24'h0, stateReg.homeMode};
        ADDR_HOMING_COARSE:     stateNext.rdata = {21'h0, stateReg.coarse};
        ADDR_HOMING_FINE:       stateNext.rdata = {21'h0, stateReg.fine};
        ADDR_END_SWITCH_SPAN:   stateNext.rdata = stateReg.span;
        ADDR_PRE_ZERO_POSITION: stateNext.rdata = stateReg.preZero;
        ADDR_BOOST_CURRENT:     stateNext.rdata = {24'h0, stateReg.boost};
        ADDR_EXT_INDEX_CONTROL: stateNext.rdata = {27'h0, stateReg.indexCtl};
        ADDR_FREEWHEEL_DELAY:   stateNext.rdata = {16'h0, stateReg.freeDelay};
        ADDR_LOAD_READOUT:      stateNext.rdata = {22'h0, loadValue};
        ADDR_MOTION_ERROR_FLAGS: begin
          stateNext.rdata    = {30'h0, stateReg.errFlags};
          stateNext.errFlags = 2'b00;
        end
        default:                stateNext.rdata = 32'h0000_0000;
      endcase
    end

    // Motion commands clear the error flags before new faults are added.
    if (motionCommand || homingCommand) begin
      stateNext.errFlags = 2'b00;
    end

    // Faults stop the motor and set flags; a set beats a clear.
    stateNext.stop = stallStop || devStop;
    if (stallStop) begin
      stateNext.errFlags[ERR_STALL_BIT] = 1'b1;
    end
    if (devStop) begin
      stateNext.errFlags[ERR_DEVIATION_BIT] = 1'b1;
    end

    // Current selection: boost on ramps, slow-run below threshold.
    if (accelerating) begin
      stateNext.current = (stateReg.boost == 8'h00) ? maxCurrent
                                                    : stateReg.boost;
    end else if (actualSpeed < thresholdSpeed) begin
      stateNext.current = stateReg.slowRun;
    end else begin
      stateNext.current = maxCurrent;
    end

    // Index clearing of the external encoder.
    if (indexEdge && stateReg.indexCtl[INDEX_CLEAR_BIT]
        && (stateReg.indexArmed || stateReg.indexCtl[INDEX_EVERY_BIT])) begin
      stateNext.clrEnc = 1'b1;
      if (!stateReg.indexCtl[INDEX_EVERY_BIT]) begin
        stateNext.indexArmed = 1'b0;
      end
    end

    // Freewheel: count ticks while stopped, cut power at the delay.
    if (actualSpeed != 11'h000 || stateReg.freeDelay == 16'h0000) begin
      stateNext.tickCnt = 32'h0000_0000;
      stateNext.freeCnt = 16'h0000;
      stateNext.cut     = 1'b0;
    end else if (!stateReg.cut) begin
      if (stateReg.tickCnt == 32'(TICK_CYCLES - 1)) begin
        stateNext.tickCnt = 32'h0000_0000;
        stateNext.freeCnt = stateReg.freeCnt + 16'h0001;
        if (stateReg.freeCnt + 16'h0001 >= stateReg.freeDelay) begin
          stateNext.cut = 1'b1;
        end
      end else begin
        stateNext.tickCnt = stateReg.tickCnt + 32'h0000_0001;
      end
    end

    // Capture on the zeroing pulse itself: the motor may take one more
    // step after the decision, and the counter is cleared only now.
    if (stateReg.zeroPos) begin
      stateNext.preZero = actualPosition;
    end

    // Reference search sequencer.
    unique case (stateReg.hstate)
      HS_IDLE: begin
        if (homingCommand) begin
          if (baseMode < BASE_MODE_MIN || baseMode > BASE_MODE_MAX) begin
            stateNext.reject = 1'b1;
          end else begin
            stateNext.secondPass = 1'b0;
            stateNext.hstate     = HS_FIRST;
          end
        end
      end
      HS_FIRST: begin
        // Coarse run toward the first target.
        unique case (baseMode)
          6'h01, 6'h04: if (refSwitch) stateNext.hstate = HS_LEAVE;
          6'h02, 6'h03: if (rightStop) begin
            stateNext.firstPos = actualPosition;
            stateNext.hstate   = HS_FAR;
          end
          6'h05: if (homeActive) stateNext.hstate = HS_LEAVE;
                 else if (leftStop) stateNext.hstate = HS_BACK;
          6'h06: if (homeActive) stateNext.hstate = HS_LEAVE;
                 else if (rightStop) stateNext.hstate = HS_BACK;
          default: if (homeActive) stateNext.hstate = HS_LEAVE;
        endcase
      end
      HS_BACK: begin
        // Reversed run in mode 5 or 6 until the home switch shows.
        if (homeActive) stateNext.hstate = HS_LEAVE;
      end
      HS_FAR: begin
        // Modes 2 and 3 travel to the left switch after the right.
        if (leftStop) begin
          stateNext.span   = stateReg.firstPos - actualPosition;
          stateNext.hstate = HS_LEAVE;
        end
      end
      HS_LEAVE: begin
        // Fine run until the switch releases: the switching point.
        if ((baseMode <= 6'h04 && !refSwitch && baseMode != 6'h02
             && baseMode != 6'h03)
            || ((baseMode == 6'h02 || baseMode == 6'h03) && !leftStop)
            || (baseMode >= 6'h05 && !homeActive)) begin
          if ((baseMode == 6'h03 || baseMode == 6'h04)
              && !stateReg.secondPass) begin
            stateNext.secondPass = 1'b1;
          end else begin
            stateNext.zeroPos = 1'b1;
            stateNext.hstate  = HS_DONE;
          end
        end
      end
      HS_DONE: begin
        if (motionDone) stateNext.hstate = HS_IDLE;
      end
      default: stateNext.hstate = HS_IDLE;
    endcase
    if ((stallStop || devStop || motionCommand)
        && stateReg.hstate != HS_IDLE) begin
      stateNext.hstate = HS_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register the state.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stateReg           <= '0;
      stateReg.slowRun   <= RST_SLOW_RUN_CURRENT;
      stateReg.homeMode  <= RST_HOMING_MODE;
      stateReg.coarse    <= RST_HOMING_SPEED;
      stateReg.fine      <= RST_HOMING_SPEED;
      stateReg.boost     <= RST_BOOST_CURRENT;
      stateReg.indexCtl  <= RST_INDEX_CONTROL;
      stateReg.freeDelay <= RST_FREEWHEEL_DELAY;
      stateReg.hstate    <= HS_IDLE;
    end else begin
      stateReg <= stateNext;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; the fine speed is used only in HS_LEAVE, while leaving the switch.
  always_comb begin
    regRdata        = stateReg.rdata;
    regAck          = stateReg.ack;
    homingRejected  = stateReg.reject;
    homingBusy      = stateReg.hstate != HS_IDLE;
    motorCurrent    = stateReg.current;
    randomOffTime   = stateReg.randomOff;
    powerCut        = stateReg.cut;
    motorStop       = stateReg.stop;
    zeroPosition    = stateReg.zeroPos;
    clearExtEncoder = stateReg.clrEnc;
    homingMove      = stateReg.hstate inside {HS_FIRST, HS_BACK, HS_FAR,
                                              HS_LEAVE};
    homingSpeed     = (stateReg.hstate == HS_LEAVE) ? stateReg.fine
                                                    : stateReg.coarse;
    // Direction per phase; leaving a switch means moving away from it.
    unique case (stateReg.hstate)
      HS_FIRST: homingDirPos = baseMode inside {6'h02, 6'h03, 6'h06, 6'h07}
                               || ((baseMode == 6'h01 || baseMode == 6'h04)
                                   && stateReg.homeMode[RIGHT_REF_BIT]);
      HS_BACK:  homingDirPos = baseMode == 6'h05;
      HS_FAR:   homingDirPos = 1'b0;
      // Modes 2 and 3 end on the left switch, so they leave it upward.
      HS_LEAVE: homingDirPos = stateReg.secondPass
                               ? (baseMode <= 6'h04
                                  && stateReg.homeMode[RIGHT_REF_BIT])
                               : !(baseMode inside {6'h06, 6'h07}
                                   || (baseMode inside {6'h01, 6'h04}
                                   && stateReg.homeMode[RIGHT_REF_BIT]));
      default:  homingDirPos = 1'b0;
    endcase
  end

endmodule : axis_homing_status

// ---- verification/axis_homing_status_props.sv ----
/* Checker for the axis block: register port, homing start, fault stop
   and freewheel relations. Assumes it is bound into the axis block. */
`timescale 1ns/100ps
module axis_homing_status_props
  import axis_homing_pkg::*;
(
  // Clock and reset.
  input wire logic        clk,
  input wire logic        arst_n,
  // Register port.
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWdata,
  input wire logic [31:0] regRdata,
  input wire logic        regAck,
  // Homing.
  input wire logic        homingCommand,
  input wire logic        homingRejected,
  input wire logic        homingBusy,
  input wire logic        homingMove,
  input wire logic        zeroPosition,
  // Status and drive.
  input wire logic [10:0] actualSpeed,
  input wire logic [10:0] stallStopSpeed,
  input wire logic [31:0] actualPosition,
  input wire logic [31:0] encoderPosition,
  input wire logic [31:0] maxDeviation,
  input wire logic [9:0]  loadValue,
  input wire logic        randomOffTime,
  input wire logic        powerCut,
  input wire logic        motorStop
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////
  // Fault causes worked out apart from the design.
  logic [31:0] diff;
  logic [31:0] mag;
  logic        fault;
  assign diff  = actualPosition - encoderPosition;
  assign mag   = diff[31] ? -diff : diff;
  assign fault = ((actualSpeed > stallStopSpeed) && (loadValue == 10'h000))
              || ((maxDeviation != 32'h0) && (mag > maxDeviation));
  sequence s_access; regWrite || regRead; endsequence
  sequence s_cmdIdle; homingCommand && !homingBusy; endsequence
  sequence s_offWr; regWrite && regAddr == ADDR_RANDOM_OFF_MODE; endsequence
  property p_ack; s_access |=> regAck; endproperty
  a_ack: assert property (p_ack) else $error("access not acknowledged");
  property p_unmapped; regRead && regAddr == 8'hB9 |=> regRdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_offTime;
    s_offWr ##1 !(regWrite && regAddr == ADDR_RANDOM_OFF_MODE)
      |=> randomOffTime == $past(regWdata[0], 2);
  endproperty
  a_offTime: assert property (p_offTime) else $error("off mode");
  property p_reject;
    homingRejected |-> $past(homingCommand) && !$past(homingBusy);
  endproperty
  a_reject: assert property (p_reject) else $error("bad reject");
  property p_start; s_cmdIdle |=> homingBusy != homingRejected; endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_idle; !homingBusy |-> !homingMove; endproperty
  a_idle: assert property (p_idle) else $error("move while idle");
  property p_zeroPulse; $rose(zeroPosition) |=> !zeroPosition; endproperty
  a_zeroPulse: assert property (p_zeroPulse) else $error("zero");
  property p_stop; fault |=> motorStop; endproperty
  a_stop: assert property (p_stop) else $error("no stop");
  property p_noStop; !fault |=> !motorStop; endproperty
  a_noStop: assert property (p_noStop) else $error("stop");
  property p_run; actualSpeed != 11'h000 |=> !powerCut; endproperty
  a_run: assert property (p_run) else $error("cut while moving");
endmodule : axis_homing_status_props

bind axis_homing_status axis_homing_status_props u_props (.clk, .arst_n,
  .regWrite, .regRead, .regAddr, .regWdata, .regRdata, .regAck,
  .homingCommand, .homingRejected, .homingBusy, .homingMove, .zeroPosition,
  .actualSpeed, .stallStopSpeed, .actualPosition, .encoderPosition,
  .maxDeviation, .loadValue, .randomOffTime, .powerCut, .motorStop);

// ---- verification/stepper_axis_model.sv ----
/* Behavioural motor with stop and home switches for the axis bench.
   Assumes one step of travel per clock while the axis commands motion. */
`timescale 1ns/100ps
module stepper_axis_model (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Commands from the axis.
  input  wire logic        homingMove,
  input  wire logic        homingDirPos,
  input  wire logic [10:0] homingSpeed,
  input  wire logic        zeroPosition,
  // Bench controls.
  input  wire logic [10:0] speedIn,
  input  wire logic        placeEn,
  input  wire logic [31:0] placePos,
  // Motor state.
  output logic      [31:0] actualPosition,
  output logic      [10:0] actualSpeed,
  output logic             leftStop,
  output logic             rightStop,
  output logic             homeSwitch,
  output logic             motionDone,
  output logic      [31:0] preZero
);
  logic signed [31:0] physPos;
  logic signed [31:0] zeroRef;
  // Travel, counter zeroing and the count held just before zeroing.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      physPos <= 32'sh0;
      zeroRef <= 32'sh0;
      preZero <= 32'h0;
    end else if (placeEn) begin
      physPos <= placePos;
    end else begin
      if (zeroPosition) begin
        zeroRef <= physPos;
        preZero <= physPos - zeroRef;
      end
      if (homingMove) begin
        physPos <= homingDirPos ? physPos + 1 : physPos - 1;
      end
    end
  end
  // Fixed switch bands; the home band lies between the two stops.
  assign leftStop       = physPos <= -50;
  assign rightStop      = physPos >= 100;
  assign homeSwitch     = physPos >= 20 && physPos <= 30;
  assign actualPosition = physPos - zeroRef;
  assign actualSpeed    = homingMove ? homingSpeed : speedIn;
  assign motionDone     = !homingMove;
endmodule : stepper_axis_model

// ---- verification/stepper_homing_and_status_tb.sv ----
/* Self-checking bench for the axis block driving a motor model.
   Assumes the shared package; inputs change on the falling edge. */
`timescale 1ns/100ps
module stepper_homing_and_status_tb import axis_homing_pkg::*;;
  logic clk = 0, arst_n = 0, regWrite = 0, regRead = 0, placeEn = 0;
  logic homingCommand = 0, motionCommand = 0, accelerating = 0;
  logic indexPulse = 0, regAck, homingRejected, homingBusy, motionDone;
  logic leftStop, rightStop, homeSwitch, randomOffTime, powerCut;
  logic motorStop, homingDirPos, homingMove, zeroPosition, clearExtEncoder;
  logic [7:0]  regAddr = 8'h00, maxCurrent = 8'hC8, motorCurrent;
  logic [31:0] regWdata = 0, maxDeviation = 0, encOff = 0, placePos = 0;
  logic [31:0] q, regRdata, actualPosition, encoderPosition, preZero;
  logic [10:0] speedIn = 11'h005, actualSpeed, homingSpeed;
  logic [10:0] thresholdSpeed = 11'h064, stallStopSpeed = 11'h00A;
  logic [9:0]  loadValue = 10'h1F4;
  int errorCnt = 0, cmpCount = 0, n;
  logic [7:0]  ra [8] = '{8'hB7, 8'hB8, 8'hC1, 8'hC2, 8'hC3, 8'hC8, 8'hC9,
                          8'hCC};
  logic [31:0] rm [8] = '{32'hFF, 32'h1, 32'hFF, 32'h7FF, 32'h7FF, 32'hFF,
                          32'h1F, 32'hFFFF};
  ////////////////////////////////////////
  axis_homing_status #(.TICK_CYCLES(4)) DUT (.clk, .arst_n, .regWrite,
    .regRead, .regAddr, .regWdata, .regRdata, .regAck, .homingCommand,
    .motionCommand, .homingRejected, .homingBusy, .actualSpeed,
    .accelerating, .motionDone, .thresholdSpeed, .stallStopSpeed,
    .actualPosition, .encoderPosition, .maxDeviation, .loadValue,
    .maxCurrent, .leftStop, .rightStop, .homeSwitch, .indexPulse,
    .motorCurrent, .randomOffTime, .powerCut, .motorStop, .homingSpeed,
    .homingDirPos, .homingMove, .zeroPosition, .clearExtEncoder);
  stepper_axis_model u_motor (.clk, .arst_n, .homingMove, .homingDirPos,
    .homingSpeed, .zeroPosition, .speedIn, .placeEn, .placePos,
    .actualPosition, .actualSpeed, .leftStop, .rightStop, .homeSwitch,
    .motionDone, .preZero);
  // The encoder follows the motor with an offset used to force deviation.
  assign encoderPosition = actualPosition + encOff;
  always #20 clk = ~clk;
  ////////////////////////////////////////
  // Comparison, verdict and register access.
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmpCount++;
    if (s !== e) begin
      errorCnt++;
      $display("Error at %0t: saw %h wanted %h", $time, s, e);
    end
  endtask : chk
  task automatic summarize;
    $display("Compares %0d, mismatches %0d", cmpCount, errorCnt);
    if (errorCnt == 0 && cmpCount > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr = a; regWdata = d; regWrite = 1; @(negedge clk);
    regWrite = 0; @(negedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    regAddr = a; regRead = 1; @(negedge clk);
    regRead = 0; d = regRdata; @(negedge clk);
  endtask : rd
  // A fault held one cycle, then removed before the flags are read.
  task automatic fault(input logic [10:0] s, input logic [9:0] l,
                       input logic [31:0] o, input logic [31:0] e);
    speedIn = s; loadValue = l; encOff = o; @(negedge clk);
    speedIn = 0; loadValue = 10'h1F4; encOff = 0; @(negedge clk);
    rd(ADDR_MOTION_ERROR_FLAGS, q); chk(q, e);
  endtask : fault
  // Two index events at the active level; clear pulses are counted.
  task automatic idx(input logic [4:0] c, input logic lvl, input int e);
    indexPulse = lvl; wr(ADDR_EXT_INDEX_CONTROL, {27'h0, c}); n = 0;
    repeat (2) begin
      indexPulse = !lvl; @(negedge clk); indexPulse = lvl;
      repeat (5) begin n += clearExtEncoder; @(negedge clk); end
    end
    chk(n, e);
  endtask : idx
  task automatic home(input logic [7:0] m, input logic [31:0] p,
                      input logic d);
    placePos = p; placeEn = 1; @(negedge clk); placeEn = 0;
    wr(ADDR_HOMING_MODE, {24'h0, m});
    homingCommand = 1; @(negedge clk); homingCommand = 0;
    chk(homingBusy, 1);
    chk(homingDirPos, d);
    chk(homingSpeed, 32'd100);
    for (n = 0; n < 3000 && homingBusy; n++) @(negedge clk);
    if (n == 3000) begin chk(0, 1); summarize(); end
    rd(ADDR_PRE_ZERO_POSITION, q); chk(q, preZero);
    if (m == 8'd2 || m == 8'd3) begin
      rd(ADDR_END_SWITCH_SPAN, q);
      chk($signed(q) > 145 && $signed(q) < 155, 1);
    end
  endtask : home
  ////////////////////////////////////////
  // Main sequence: registers, current, freewheel, faults, index, homing.
  initial begin
    repeat (20) @(negedge clk);
    arst_n = 1; @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      rd(ra[i], q); chk(q, ra[i] == ADDR_HOMING_MODE);
      wr(ra[i], 32'hFFFFFFFF); rd(ra[i], q); chk(q, rm[i]);
      wr(ra[i], 0);
    end
    wr(ADDR_END_SWITCH_SPAN, 7); rd(ADDR_END_SWITCH_SPAN, q); chk(q, 0);
    rd(8'hB9, q); chk(q, 0);
    for (int b = 1; b >= 0; b--) begin
      wr(ADDR_RANDOM_OFF_MODE, b); @(negedge clk);
      chk(randomOffTime, b);
    end
    wr(ADDR_SLOW_RUN_CURRENT, 8'h40);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_BOOST_CURRENT, i < 2 ? 8'h80 : 8'h00);
      speedIn = i == 3 ? 11'd150 : 11'd50; accelerating = i inside {1, 2};
      repeat (3) @(negedge clk);
      chk(motorCurrent, i == 0 ? 8'h40 : i == 1 ? 8'h80 : 8'hC8);
    end
    accelerating = 0; wr(ADDR_FREEWHEEL_DELAY, 3); speedIn = 0;
    for (n = 0; n < 40 && !powerCut; n++) @(negedge clk);
    chk(n >= 10 && n <= 14, 1);
    speedIn = 5; wr(ADDR_FREEWHEEL_DELAY, 0); speedIn = 0;
    repeat (30) @(negedge clk);
    chk(powerCut, 0);
    fault(20, 0, 0, 1);
    rd(ADDR_MOTION_ERROR_FLAGS, q); chk(q, 0);
    fault(5, 0, 0, 0);
    maxDeviation = 5; fault(0, 10'h1F4, 10, 2);
    fault(20, 0, 10, 3);
    maxDeviation = 0; fault(0, 10'h1F4, 10, 0);
    speedIn = 20; loadValue = 0; @(negedge clk);
    speedIn = 0; loadValue = 10'h1F4; @(negedge clk);
    motionCommand = 1; @(negedge clk); motionCommand = 0;
    rd(ADDR_MOTION_ERROR_FLAGS, q); chk(q, 0);
    loadValue = 10'h3FF; rd(ADDR_LOAD_READOUT, q); chk(q, 32'h3FF);
    loadValue = 10'h1F4;
    idx(5'h14, 0, 1); idx(5'h1C, 0, 2); idx(5'h18, 0, 0);
    idx(5'h0C, 1, 2); idx(5'h04, 1, 1);
    wr(ADDR_HOMING_COARSE, 100); wr(ADDR_HOMING_FINE, 20);
    home(1, 0, 0); home(2, 0, 1); home(3, 0, 1); home(4, 0, 0);
    home(5, 60, 0); home(6, -20, 1);
    home(7, -20, 1); home(8, 60, 0);
    home(65, 0, 1); home(68, 0, 1);
    home(136, -60, 0);
    foreach (ra[i]) if (i < 4) begin
      wr(ADDR_HOMING_MODE, i == 0 ? 8'h00 : i == 1 ? 8'h49
                           : i == 2 ? 8'h89 : 8'h21);
      homingCommand = 1; @(negedge clk); homingCommand = 0;
      chk(homingRejected, 1);
      chk(homingBusy, 0);
    end
    summarize();
  end
endmodule : stepper_homing_and_status_tb
